// ### verilog/pmt_phy_dev.sv
// PHY end: management slave, interrupt, crossover and data path muxing.
// Assumes MDC well below core_clk/4; RMII and line pins are resynchronised.
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module pmt_phy_dev
   import pmt_pkg::*;
#(
   parameter logic [15:0] ID1_VAL = 16'h1234,  // Arbitrary identity value
   parameter logic [15:0] ID2_VAL = 16'h5678,  // Arbitrary identity value
   parameter logic CLK50_DEFAULT = 1'b0
)(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Management link
   pmt_link_if.dev lnk,
   // Straps and analog-side status
   input wire logic phy_address_strap,
   input wire logic pair_partner_crossed,
   input wire logic [7:0] int_event,
   // MAC-side RMII
   input wire logic rmii_tx_en,
   input wire logic [1:0] rmii_txd,
   output logic rmii_crs_dv,
   output logic [1:0] rmii_rxd,
   // Line side
   input wire logic line_rx_dv,
   input wire logic [1:0] line_rxd,
   output logic line_tx_en,
   output logic [1:0] line_txd,
   // Status
   output logic interrupt_request_out,
   output logic mdix_active,
   output logic clock_mode_50m,
   output logic b2b_active
);
   typedef enum {DEV_PRE, DEV_HDR, DEV_TA, DEV_RD, DEV_WR} pmt_dev_state_e;

   // ==========================================================
   // Input synchronisers
   localparam int NSYNC = 10;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] s1_reg;
   logic [NSYNC-1:0] s2_reg;
   assign pin_raw = {lnk.mdc, lnk.mdio, phy_address_strap,
      pair_partner_crossed, rmii_tx_en, rmii_txd, line_rx_dv, line_rxd};
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
      end
      else
      begin
         s1_reg <= pin_raw;
         s2_reg <= s1_reg;
      end
   end
   logic mdc_s;
   logic mdio_s;
   logic strap_s;
   logic cross_s;
   logic tx_en_s;
   logic [1:0] txd_s;
   logic lrx_dv_s;
   logic [1:0] lrxd_s;
   assign {mdc_s, mdio_s, strap_s, cross_s, tx_en_s, txd_s, lrx_dv_s,
      lrxd_s} = s2_reg;

   logic mdc_d_reg;
   logic rise;
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         mdc_d_reg <= 1'b0;
      else
         mdc_d_reg <= mdc_s;
   end
   assign rise = mdc_s & ~mdc_d_reg;

   // ==========================================================
   // Strap capture after reset release
   logic [1:0] cap_cnt_reg;
   logic strap_hi_reg;
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cap_cnt_reg <= 2'h0;
         strap_hi_reg <= 1'b0;
      end
      else if (cap_cnt_reg != 2'h3)
      begin
         cap_cnt_reg <= cap_cnt_reg + 2'h1;
         if (cap_cnt_reg == 2'h2)
            strap_hi_reg <= strap_s;
      end
   end

   // ==========================================================
   // Registers
   logic [15:0] bcr_reg;
   logic [15:0] ovr_reg;
   logic [15:0] ctl2_reg;
   logic [7:0] int_en_reg;
   logic [7:0] int_st_reg;
   logic wr_go;
   logic rd_go;
   logic [4:0] rg_reg;
   logic [15:0] wdata;

   function automatic logic [15:0] reg_read(input logic [4:0] a,
      input logic [15:0] b, input logic [15:0] o, input logic [15:0] c,
      input logic [15:0] i);
      case (a)
         REG_BCR: reg_read = b;
         REG_BSR: reg_read = BSR_VAL;
         REG_ID1: reg_read = ID1_VAL;
         REG_ID2: reg_read = ID2_VAL;
         REG_OVR: reg_read = o;
         REG_INT: reg_read = i;
         REG_CTL2: reg_read = c;
         default: reg_read = 16'h0000;
      endcase
   endfunction : reg_read

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bcr_reg <= BCR_RST;
         ovr_reg <= OVR_RST;
         ctl2_reg <= CTL2_RST;
         int_en_reg <= INT_RST[15:8];
      end
      else if (cap_cnt_reg == 2'h1)
         ctl2_reg[CTL2_CLK50] <= CLK50_DEFAULT;
      else if (wr_go)
      begin
         case (rg_reg)
            REG_BCR: bcr_reg <= wdata;
            REG_OVR: ovr_reg <= wdata;
            REG_CTL2: ctl2_reg <= wdata;
            REG_INT: int_en_reg <= wdata[15:8];
            default: ;
         endcase
      end
   end

   // Set wins over the read-clear
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         int_st_reg <= INT_RST[7:0];
      else if (rd_go && rg_reg == REG_INT)
         int_st_reg <= int_event;
      else
         int_st_reg <= int_st_reg | int_event;
   end

   // ==========================================================
   // Management frame engine
   pmt_dev_state_e st_reg;
   logic [5:0] ones_reg;
   logic [4:0] cnt_reg;
   logic [15:0] sh_reg;
   logic own_match;
   logic [12:0] hdr;
   logic [4:0] own_addr;
   assign hdr = {sh_reg[11:0], mdio_s};
   assign own_addr = strap_hi_reg ? ADDR_STRAP_HI : ADDR_STRAP_LO;
   assign own_match = (hdr[9:5] == own_addr) ||
      (hdr[9:5] == ADDR_BCAST && !ovr_reg[OVR_BCAST_OFF]);
   assign wdata = {sh_reg[14:0], mdio_s};
   assign wr_go = rise && st_reg == DEV_WR && cnt_reg == 5'd17;
   assign rd_go = rise && st_reg == DEV_TA;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg <= DEV_PRE;
         ones_reg <= 6'h00;
         cnt_reg <= 5'h00;
         sh_reg <= 16'h0000;
         rg_reg <= 5'h00;
         lnk.dev_mdio_o <= 1'b1;
         lnk.dev_mdio_oe <= 1'b0;
      end
      else if (rise)
      begin
         case (st_reg)
            DEV_PRE:
            begin
               cnt_reg <= 5'h01;
               if (mdio_s)
               begin
                  if (ones_reg != 6'(PRE_LEN))
                     ones_reg <= ones_reg + 6'h01;
               end
               else
               begin
                  ones_reg <= 6'h00;
                  if (ones_reg == 6'(PRE_LEN))
                     st_reg <= DEV_HDR;
               end
            end
            DEV_HDR:
            begin
               sh_reg <= {sh_reg[14:0], mdio_s};
               cnt_reg <= cnt_reg + 5'h01;
               if (cnt_reg == 5'(HDR_BITS))
               begin
                  cnt_reg <= 5'h00;
                  rg_reg <= hdr[4:0];
                  st_reg <= DEV_PRE;
                  if (hdr[12] && own_match && hdr[11:10] == OP_READ)
                     st_reg <= DEV_TA;
                  else if (hdr[12] && own_match && hdr[11:10] == OP_WRITE)
                     st_reg <= DEV_WR;
               end
            end
            DEV_TA:
            begin
               lnk.dev_mdio_oe <= 1'b1;
               lnk.dev_mdio_o <= 1'b0;
               sh_reg <= reg_read(rg_reg, bcr_reg, ovr_reg, ctl2_reg,
                  {int_en_reg, int_st_reg});
               st_reg <= DEV_RD;
            end
            DEV_RD:
            begin
               cnt_reg <= cnt_reg + 5'h01;
               if (cnt_reg == 5'(DATA_BITS))
               begin
                  lnk.dev_mdio_oe <= 1'b0;
                  lnk.dev_mdio_o <= 1'b1;
                  st_reg <= DEV_PRE;
               end
               else
               begin
                  lnk.dev_mdio_o <= sh_reg[15];
                  sh_reg <= {sh_reg[14:0], 1'b0};
               end
            end
            DEV_WR:
            begin
               sh_reg <= {sh_reg[14:0], mdio_s};
               cnt_reg <= cnt_reg + 5'h01;
               if (cnt_reg == 5'd17)
                  st_reg <= DEV_PRE;
            end
            default: st_reg <= DEV_PRE;
         endcase
      end
   end

   // ==========================================================
   // Interrupt, crossover and data paths
   logic pending;
   logic local_loop;
   logic remote_loop;
   logic b2b;
   logic fwd_ok;
   assign pending = |(int_en_reg & int_st_reg);
   assign local_loop = bcr_reg[BCR_LOOP];
   assign remote_loop = ctl2_reg[CTL2_RLOOP] && bcr_reg[BCR_SPEED] &&
      bcr_reg[BCR_DUPLEX];
   assign b2b = ovr_reg[OVR_B2B_A] && ovr_reg[OVR_B2B_B] &&
      ctl2_reg[CTL2_CLK50];
   // Repeater traffic is held off unless the link runs at 100 Mbps
   assign fwd_ok = !b2b || bcr_reg[BCR_SPEED];

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         interrupt_request_out <= 1'b1;
         mdix_active <= 1'b0;
         clock_mode_50m <= 1'b0;
         b2b_active <= 1'b0;
      end
      else
      begin
         interrupt_request_out <= ctl2_reg[CTL2_INT_POL] ? pending
            : ~pending;
         mdix_active <= ctl2_reg[CTL2_AUTO_OFF] ?
            ctl2_reg[CTL2_MDIX_SEL] : cross_s;
         clock_mode_50m <= ctl2_reg[CTL2_CLK50];
         b2b_active <= b2b && fwd_ok;
      end
   end

   // Idle dibits are forced to 00 so stray values never leak through
   // Both RMII directions share the one reference clock of this block
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rmii_crs_dv <= 1'b0;
         rmii_rxd <= 2'h0;
         line_tx_en <= 1'b0;
         line_txd <= 2'h0;
      end
      else
      begin
         if (local_loop)
         begin
            rmii_crs_dv <= tx_en_s;
            rmii_rxd <= tx_en_s ? txd_s : 2'h0;
         end
         else
         begin
            rmii_crs_dv <= lrx_dv_s && fwd_ok;
            rmii_rxd <= (lrx_dv_s && fwd_ok) ? lrxd_s : 2'h0;
         end
         if (remote_loop)
         begin
            line_tx_en <= lrx_dv_s;
            line_txd <= lrx_dv_s ? lrxd_s : 2'h0;
         end
         else
         begin
            line_tx_en <= tx_en_s && fwd_ok && !local_loop;
            line_txd <= (tx_en_s && fwd_ok && !local_loop) ? txd_s
               : 2'h0;
         end
      end
   end
endmodule : pmt_phy_dev

// ### pkg/pmt_pkg.sv
// Constants shared by both ends of the management link and the PHY model.
// Assumes a 25 MHz core clock on both ends.
package pmt_pkg;
   // ==========================================================
   // Frame layout
   localparam int PRE_LEN = 32;
   localparam int HDR_BITS = 13;
   localparam int FRAME_BITS = 64;
   localparam int TA_FIRST = 46;
   localparam int DATA_FIRST = 48;
   localparam int DATA_BITS = 16;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] START_PAT = 2'h1;
   localparam logic [1:0] TA_WRITE = 2'h2;
   localparam logic [4:0] ADDR_STRAP_LO = 5'h00;
   localparam logic [4:0] ADDR_STRAP_HI = 5'h03;
   localparam logic [4:0] ADDR_BCAST = 5'h00;
   // ==========================================================
   // Device register map
   localparam logic [4:0] REG_BCR = 5'h00;
   localparam logic [4:0] REG_BSR = 5'h01;
   localparam logic [4:0] REG_ID1 = 5'h02;
   localparam logic [4:0] REG_ID2 = 5'h03;
   localparam logic [4:0] REG_OVR = 5'h16;
   localparam logic [4:0] REG_INT = 5'h1B;
   localparam logic [4:0] REG_CTL2 = 5'h1F;
   localparam int BCR_LOOP = 14;
   localparam int BCR_SPEED = 13;
   localparam int BCR_ANEG = 12;
   localparam int BCR_DUPLEX = 8;
   localparam int OVR_BCAST_OFF = 9;
   localparam int OVR_B2B_A = 6;
   localparam int OVR_B2B_B = 1;
   localparam int CTL2_MDIX_SEL = 14;
   localparam int CTL2_AUTO_OFF = 13;
   localparam int CTL2_INT_POL = 9;
   localparam int CTL2_CLK50 = 7;
   localparam int CTL2_RLOOP = 2;
   localparam logic [15:0] BCR_RST = 16'h3100;
   localparam logic [15:0] OVR_RST = 16'h0000;
   localparam logic [15:0] CTL2_RST = 16'h0000;
   localparam logic [15:0] INT_RST = 16'h0000;
   localparam logic [15:0] BSR_VAL = 16'h7809;
   // ==========================================================
   // Controller timing and software registers
   localparam int CORE_CLK_NS = 40;
   localparam int MDC_PERIOD_NS = 320;
   localparam int MDC_HALF_CYC = MDC_PERIOD_NS / (2 * CORE_CLK_NS);
   localparam logic [3:0] CR_CMD = 4'h0;
   localparam logic [3:0] CR_STAT = 4'h4;
   localparam int CMD_WR_BIT = 26;
   localparam int CMD_PHY_LSB = 21;
   localparam int CMD_REG_LSB = 16;
   localparam int STAT_BUSY = 31;
   localparam int STAT_DONE = 30;
endpackage : pmt_pkg

// ### pkg/pmt_link_if.sv
// Two-wire management link between controller and PHY.
// The shared data wire idles high through a pull-up.
`timescale 1ns/1ps
interface pmt_link_if;
   logic mdc;
   logic ctl_mdio_o;
   logic ctl_mdio_oe;
   logic dev_mdio_o;
   logic dev_mdio_oe;
   wire mdio;
   assign mdio = ctl_mdio_oe ? ctl_mdio_o : dev_mdio_oe ? dev_mdio_o : 1'b1;
   modport dev (input mdc, input mdio, output dev_mdio_o, output dev_mdio_oe);
   modport ctl (output mdc, output ctl_mdio_o, output ctl_mdio_oe,
      input mdio);
endinterface : pmt_link_if

// ### verilog/pmt_mgmt_ctl.sv
// Controller end: runs one management frame per software command.
// Assumes software polls the status register for completion.
`timescale 1ns/1ps
module pmt_mgmt_ctl
   import pmt_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Software port
   input wire logic [3:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [31:0] sw_rdata,
   // Management link
   pmt_link_if.ctl lnk
);
   // ==========================================================
   // Link data synchroniser
   logic m1_reg;
   logic m2_reg;
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         m1_reg <= 1'b1;
         m2_reg <= 1'b1;
      end
      else
      begin
         m1_reg <= lnk.mdio;
         m2_reg <= m1_reg;
      end
   end

   // ==========================================================
   // Frame sequencer
   logic busy_reg;
   logic done_reg;
   logic is_read_reg;
   logic [63:0] frame_reg;
   logic [6:0] idx_reg;
   logic [2:0] div_reg;
   logic [15:0] rdata_reg;
   logic start;
   logic tick;
   logic [6:0] idx_next;
   assign start = sw_wr && sw_addr == CR_CMD && !busy_reg;
   assign tick = busy_reg && div_reg == 3'(MDC_HALF_CYC - 1);
   assign idx_next = idx_reg + 7'h01;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         busy_reg <= 1'b0;
         is_read_reg <= 1'b0;
         frame_reg <= '0;
         idx_reg <= 7'h00;
         div_reg <= 3'h0;
         rdata_reg <= 16'h0000;
         lnk.mdc <= 1'b0;
         lnk.ctl_mdio_o <= 1'b1;
         lnk.ctl_mdio_oe <= 1'b0;
      end
      else if (start)
      begin
         busy_reg <= 1'b1;
         is_read_reg <= !sw_wdata[CMD_WR_BIT];
         // Preamble, start, opcode, addresses, turnaround, data
         frame_reg <= {32'hFFFF_FFFF, START_PAT,
            sw_wdata[CMD_WR_BIT] ? OP_WRITE : OP_READ,
            sw_wdata[CMD_PHY_LSB +: 5], sw_wdata[CMD_REG_LSB +: 5],
            TA_WRITE, sw_wdata[15:0]};
         idx_reg <= 7'h00;
         div_reg <= 3'h0;
         lnk.ctl_mdio_o <= 1'b1;
         lnk.ctl_mdio_oe <= 1'b1;
      end
      else if (busy_reg)
      begin
         div_reg <= tick ? 3'h0 : div_reg + 3'h1;
         if (tick)
         begin
            lnk.mdc <= !lnk.mdc;
            if (!lnk.mdc)
            begin
               // Device launched this bit one MDC period earlier
               if (is_read_reg && idx_reg >= 7'(DATA_FIRST))
                  rdata_reg <= {rdata_reg[14:0], m2_reg};
            end
            else if (idx_next == 7'(FRAME_BITS))
            begin
               busy_reg <= 1'b0;
               lnk.ctl_mdio_oe <= 1'b0;
               lnk.ctl_mdio_o <= 1'b1;
            end
            else
            begin
               // Data moves half a period after the rising edge
               idx_reg <= idx_next;
               frame_reg <= {frame_reg[62:0], 1'b0};
               lnk.ctl_mdio_o <= frame_reg[62];
               lnk.ctl_mdio_oe <= !(is_read_reg &&
                  idx_next >= 7'(TA_FIRST));
            end
         end
      end
   end

   // ==========================================================
   // Software registers; completion set wins over read-clear
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         done_reg <= 1'b0;
      else if (tick && lnk.mdc && idx_next == 7'(FRAME_BITS))
         done_reg <= 1'b1;
      else if (sw_rd && sw_addr == CR_STAT)
         done_reg <= 1'b0;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         sw_rdata <= 32'h0000_0000;
      else if (sw_rd && sw_addr == CR_STAT)
         sw_rdata <= {busy_reg, done_reg, 14'h0000, rdata_reg};
      else
         sw_rdata <= 32'h0000_0000;
   end
endmodule : pmt_mgmt_ctl

// ### tb/pmt_link_chk.sv
// Checker on the management link wires.
// Assumes it sits beside the interface that joins both ends.
`timescale 1ns/1ps
module pmt_link_chk
   import pmt_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Link wires
   input wire logic mdc,
   input wire logic ctl_mdio_o,
   input wire logic ctl_mdio_oe,
   input wire logic dev_mdio_oe,
   input wire logic mdio
);
   // ========================================
   // Bit index of the frame on the wire
   logic [6:0] cnt_reg;
   logic [1:0] op_reg;
   logic mdc_q;
   logic oe_q;
   logic rise;
   assign rise = mdc & ~mdc_q;
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mdc_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else
      begin
         mdc_q <= mdc;
         oe_q <= ctl_mdio_oe;
      end
   end
   // Index restarts when the controller takes the line
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         cnt_reg <= 7'h00;
      else if (ctl_mdio_oe && !oe_q)
         cnt_reg <= {6'h00, rise};
      else if (rise && cnt_reg < 7'h40)
         cnt_reg <= cnt_reg + 7'h01;
   end
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         op_reg <= 2'h0;
      else if (rise && cnt_reg == 7'h22)
         op_reg <= {mdio, 1'b0};
      else if (rise && cnt_reg == 7'h23)
         op_reg[0] <= mdio;
   end
   // ========================================
   // Properties
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   a_no_contention: assert property (!(ctl_mdio_oe && dev_mdio_oe))
      else $error("both ends drive the data line");
   a_mdc_high_half: assert property (
      $rose(mdc) |-> mdc [*4] ##1 !mdc)
      else $error("clock high phase wrong");
   a_ctl_hold_high: assert property (
      mdc && $past(mdc) && ctl_mdio_oe |-> $stable(ctl_mdio_o))
      else $error("controller moved data while clock high");
   a_preamble_ones: assert property (
      rise && ctl_mdio_oe && cnt_reg < 7'h20 |-> mdio)
      else $error("preamble bit not one");
   a_start_pattern: assert property (
      rise && cnt_reg == 7'h20 |-> !mdio ##8 mdio)
      else $error("start pattern wrong");
   // An unaddressed device stays off and the pull-up keeps the line high
   a_read_turn: assert property (
      rise && cnt_reg == 7'h2E && op_reg == OP_READ
      |-> !ctl_mdio_oe ##8 (dev_mdio_oe == !mdio))
      else $error("read turnaround wrong");
   a_write_turn: assert property (
      rise && cnt_reg == 7'h2E && op_reg == OP_WRITE
      |-> mdio && !dev_mdio_oe ##8 !mdio)
      else $error("write turnaround wrong");
   a_frame_release: assert property (
      rise && cnt_reg == 7'h3F |-> ##[1:8] !(ctl_mdio_oe || dev_mdio_oe))
      else $error("line not released after frame");
   c_read: cover property (rise && cnt_reg == 7'h3F && op_reg == OP_READ);
   c_write: cover property (rise && cnt_reg == 7'h3F && op_reg == OP_WRITE);
   c_start: cover property (rise && cnt_reg == 7'h21);
endmodule : pmt_link_chk

// ### tb/testbench.sv
// Bench: software port drives the controller, which talks to the PHY.
// Assumes both ends share core_clk and rstn.
`timescale 1ns/1ps
module testbench
   import pmt_pkg::*;
;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] sw_addr = 4'h0;
   logic [31:0] sw_wdata = 32'h0000_0000;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic [31:0] sw_rdata;
   logic strap = 1'b1;
   logic crossed = 1'b1;
   logic [7:0] int_event = 8'h00;
   logic tx_en = 1'b0;
   logic [1:0] txd = 2'h0;
   logic rx_dv = 1'b0;
   logic [1:0] rxd = 2'h0;
   logic crs_dv, irq, mdix, clk50, b2b, ltx_en;
   logic [1:0] rx_out;
   logic [1:0] ltxd;
   logic [15:0] v;
   int error_cnt = 0;
   int checks = 0;
   pmt_link_if lnk ();
   always #20 core_clk = ~core_clk;
   pmt_mgmt_ctl i_pmt_mgmt_ctl (.core_clk(core_clk), .rstn(rstn),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
      .sw_rd(sw_rd), .sw_rdata(sw_rdata), .lnk(lnk.ctl));
   pmt_phy_dev i_pmt_phy_dev (.core_clk(core_clk), .rstn(rstn),
      .lnk(lnk.dev), .phy_address_strap(strap),
      .pair_partner_crossed(crossed), .int_event(int_event),
      .rmii_tx_en(tx_en), .rmii_txd(txd), .rmii_crs_dv(crs_dv),
      .rmii_rxd(rx_out), .line_rx_dv(rx_dv), .line_rxd(rxd),
      .line_tx_en(ltx_en), .line_txd(ltxd),
      .interrupt_request_out(irq), .mdix_active(mdix),
      .clock_mode_50m(clk50), .b2b_active(b2b));
   pmt_link_chk i_pmt_link_chk (.core_clk(core_clk), .rstn(rstn),
      .mdc(lnk.mdc), .ctl_mdio_o(lnk.ctl_mdio_o),
      .ctl_mdio_oe(lnk.ctl_mdio_oe), .dev_mdio_oe(lnk.dev_mdio_oe),
      .mdio(lnk.mdio));
   // ========================================
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: %h not %h", $time, seen, exp);
      end
   endtask : check
   task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge core_clk);
      sw_wr <= 1'b0;
   endtask : sw_write
   task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge core_clk);
      sw_rd <= 1'b0;
      @(negedge core_clk);
      d = sw_rdata;
      @(posedge core_clk);
   endtask : sw_read
   // Polls until idle; a stuck busy leaves done low and is counted
   task automatic frame(input logic wr, input logic [4:0] phy,
      input logic [4:0] rg, input logic [15:0] wd, output logic [15:0] rd);
      logic [31:0] s;
      int n;
      sw_write(CR_CMD, {5'h00, wr, phy, rg, wd});
      n = 0;
      s = 32'h8000_0000;
      while (s[STAT_BUSY] !== 1'b0 && n < 400)
      begin
         sw_read(CR_STAT, s);
         n++;
      end
      check({31'h0, s[STAT_DONE]}, 32'h1);
      rd = s[15:0];
   endtask : frame
   task automatic wr16(input logic [4:0] rg, input logic [15:0] d);
      logic [15:0] x;
      frame(1'b1, ADDR_STRAP_HI, rg, d, x);
   endtask : wr16
   task automatic rd16(input logic [4:0] phy, input logic [4:0] rg,
      input logic [15:0] exp);
      logic [15:0] x;
      frame(1'b0, phy, rg, 16'h0000, x);
      check({16'h0000, x}, {16'h0000, exp});
   endtask : rd16
   task automatic bit1(input logic s, input logic e);
      check({31'h0, s}, {31'h0, e});
   endtask : bit1
   // drv is {tx_en, txd, rx_dv, rxd}
   task automatic path(input logic [5:0] drv, input logic [5:0] m,
      input logic [5:0] exp);
      {tx_en, txd, rx_dv, rxd} <= drv;
      repeat (6) @(posedge core_clk);
      check({26'h0, {crs_dv, rx_out, ltx_en, ltxd} & m}, {26'h0, exp});
   endtask : path
   task automatic pulse(input logic [7:0] e);
      int_event <= e;
      @(posedge core_clk);
      int_event <= 8'h00;
      repeat (4) @(posedge core_clk);
   endtask : pulse
   task automatic results;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   // ========================================
   // Sequence
   initial
   begin
      #2000000;
      error_cnt++;
      results();
   end
   initial
   begin
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (6) @(posedge core_clk);
      bit1(irq, 1'b1);
      bit1(mdix, 1'b1);
      crossed <= 1'b0;
      repeat (6) @(posedge core_clk);
      bit1(mdix, 1'b0);
      rd16(ADDR_STRAP_HI, REG_BCR, BCR_RST);
      rd16(ADDR_STRAP_HI, REG_BSR, BSR_VAL);
      rd16(ADDR_STRAP_HI, REG_CTL2, CTL2_RST);
      rd16(5'h01, REG_BCR, 16'hFFFF);
      rd16(ADDR_BCAST, REG_BCR, BCR_RST);
      frame(1'b1, ADDR_BCAST, REG_OVR, 16'h0200, v);
      rd16(ADDR_STRAP_HI, REG_OVR, 16'h0200);
      rd16(ADDR_BCAST, REG_BCR, 16'hFFFF);
      wr16(REG_INT, 16'h0100);
      pulse(8'h02);
      bit1(irq, 1'b1);
      pulse(8'h01);
      bit1(irq, 1'b0);
      wr16(REG_CTL2, 16'h0200);
      bit1(irq, 1'b1);
      rd16(ADDR_STRAP_HI, REG_INT, 16'h0103);
      bit1(irq, 1'b0);
      rd16(ADDR_STRAP_HI, REG_INT, 16'h0100);
      wr16(REG_CTL2, 16'h6200);
      bit1(mdix, 1'b1);
      crossed <= 1'b1;
      wr16(REG_CTL2, 16'h2200);
      bit1(mdix, 1'b0);
      path(6'b101110, 6'h3F, 6'b110101);
      path(6'b011010, 6'h3F, 6'h00);
      wr16(REG_BCR, 16'h6100);
      path(6'b110101, 6'h3F, 6'b110000);
      path(6'b011000, 6'h3F, 6'h00);
      wr16(REG_BCR, 16'h2100);
      wr16(REG_CTL2, 16'h2204);
      path(6'b101110, 6'h07, 6'b000110);
      wr16(REG_BCR, 16'h0100);
      path(6'b101110, 6'h07, 6'b000101);
      wr16(REG_OVR, 16'h0242);
      wr16(REG_BCR, 16'h2100);
      bit1(b2b, 1'b0);
      wr16(REG_CTL2, 16'h2280);
      bit1(clk50, 1'b1);
      bit1(b2b, 1'b1);
      wr16(REG_BCR, 16'h0100);
      bit1(b2b, 1'b0);
      path(6'b101110, 6'h07, 6'h00);
      results();
   end
endmodule : testbench
